// ==== src/tmr8_pkg.sv ====
// Package: register map, field positions, reset values and modes of the 8-bit timer core
package tmr8_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_COUNT    = 8'h00;
  localparam logic [7:0] ADDR_CMP_A    = 8'h04;
  localparam logic [7:0] ADDR_CMP_B    = 8'h08;
  localparam logic [7:0] ADDR_CTRL_A   = 8'h0C;
  localparam logic [7:0] ADDR_CTRL_B   = 8'h10;
  localparam logic [7:0] ADDR_FLAG     = 8'h14;
  localparam logic [7:0] ADDR_MASK     = 8'h18;
  localparam logic [7:0] ADDR_PWR      = 8'h1C;
  localparam logic [7:0] ADDR_STATUS   = 8'h20;

  // ==========================================================================
  // Field positions
  localparam int CTRLA_WGM0_POS  = 0;   // wave_mode_bit0
  localparam int CTRLA_WGM1_POS  = 1;   // wave_mode_bit1
  localparam int CTRLA_COMB_POS  = 4;   // Output action B, 2 bits
  localparam int CTRLA_COMA_POS  = 6;   // Output action A, 2 bits
  localparam int CTRLB_CS_POS    = 0;   // clock_select_field, 3 bits
  localparam int CTRLB_WGM2_POS  = 3;   // wave_mode_bit2
  localparam int CTRLB_DIR_POS   = 4;   // Direction control, 1 = down
  localparam int FLAG_OVF_POS    = 0;
  localparam int FLAG_CMPA_POS   = 1;
  localparam int FLAG_CMPB_POS   = 2;
  localparam int PWR_BIT_POS     = 0;

  // ==========================================================================
  // Values
  localparam logic [7:0] COUNT_BOTTOM  = 8'h00;
  localparam logic [7:0] COUNT_MAX     = 8'hFF;
  localparam logic [7:0] RESET_BYTE    = 8'h00;
  localparam logic       PWR_RESET     = 1'b0;

  // Clock select encodings
  localparam logic [2:0] CS_STOP       = 3'h0;
  localparam logic [2:0] CS_DIV1       = 3'h1;
  localparam logic [2:0] CS_DIV8       = 3'h2;
  localparam logic [2:0] CS_DIV64      = 3'h3;
  localparam logic [2:0] CS_DIV256     = 3'h4;
  localparam logic [2:0] CS_DIV1024    = 3'h5;
  localparam logic [2:0] CS_EXT_FALL   = 3'h6;
  localparam logic [2:0] CS_EXT_RISE   = 3'h7;

  // Waveform modes
  localparam logic [2:0] WGM_NORMAL    = 3'h0;
  localparam logic [2:0] WGM_PC_MAX    = 3'h1;
  localparam logic [2:0] WGM_CTC       = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX  = 3'h3;
  localparam logic [2:0] WGM_PC_CMPA   = 3'h5;
  localparam logic [2:0] WGM_FAST_CMPA = 3'h7;

  // Prescaler width
  localparam int PRESC_W = 10;

  // Bus answer state
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ
  } bus_state_t;

endpackage

// ==== src/tmr8_tick_gen.sv ====
// Timer tick generator: prescaler taps and synchronised external count pin
`timescale 1ns/100ps
module tmr8_tick_gen (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Control
  input  wire logic       enable,
  input  wire logic [2:0] clock_select_field,
  // External pin
  input  wire logic       ext_count_pin,
  // Tick out
  output logic            timer_tick
);

  logic [tmr8_pkg::PRESC_W-1:0] presc;
  logic                         pin_meta;
  logic                         pin_sync;
  logic                         pin_last;
  logic                         next_tick;

  // Free-running prescaler, cleared while stopped
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      presc <= '0;
    end else if (enable && clock_select_field != tmr8_pkg::CS_STOP) begin
      presc <= presc + 1'b1;
    end else begin
      presc <= '0;
    end
  end

  // Two-stage pin synchroniser
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_last <= 1'b0;
    end else begin
      pin_meta <= ext_count_pin;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // Source and edge selection
  always_comb begin
    next_tick = 1'b0;
    case (clock_select_field)
      tmr8_pkg::CS_STOP:     next_tick = 1'b0;
      tmr8_pkg::CS_DIV1:     next_tick = 1'b1;
      tmr8_pkg::CS_DIV8:     next_tick = (presc[2:0] == 3'h7);
      tmr8_pkg::CS_DIV64:    next_tick = (presc[5:0] == 6'h3F);
      tmr8_pkg::CS_DIV256:   next_tick = (presc[7:0] == 8'hFF);
      tmr8_pkg::CS_DIV1024:  next_tick = (presc == 10'h3FF);
      tmr8_pkg::CS_EXT_FALL: next_tick = pin_last && !pin_sync;
      default:               next_tick = !pin_last && pin_sync;
    endcase
  end

  assign timer_tick = enable && next_tick;

endmodule

// ==== src/tmr8_compare.sv ====
// One output-compare unit: buffered compare value, match flag and wave output
`timescale 1ns/100ps
module tmr8_compare (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Software access
  input  wire logic       wr_value,
  input  wire logic [7:0] wdata,
  input  wire logic       clr_flag,
  input  wire logic [1:0] out_action,
  // Counter side
  input  wire logic       timer_tick,
  input  wire logic [7:0] count_value,
  input  wire logic       block_match,
  input  wire logic       buffered,
  input  wire logic       update_now,
  // Results
  output logic [7:0]      cmp_value,
  output logic [7:0]      cmp_buffer,
  output logic            match,
  output logic            cmp_flag,
  output logic            wave_out
);

  // Continuous equality compare
  assign match = (count_value == cmp_value);

  // Buffer register written by software
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_buffer <= tmr8_pkg::RESET_BYTE;
    end else if (wr_value) begin
      cmp_buffer <= wdata;
    end
  end

  // Active compare value, direct or loaded at top/bottom
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_value <= tmr8_pkg::RESET_BYTE;
    end else if (wr_value && !buffered) begin
      cmp_value <= wdata;
    end else if (buffered && update_now) begin
      cmp_value <= cmp_buffer;
    end
  end

  // Flag: set on tick after match, set wins over clear
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_flag <= 1'b0;
    end else if (timer_tick && match && !block_match) begin
      cmp_flag <= 1'b1;
    end else if (clr_flag) begin
      cmp_flag <= 1'b0;
    end
  end

  // Wave output: toggle, clear or set on a counted match
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wave_out <= 1'b0;
    end else if (timer_tick && match && !block_match) begin
      case (out_action)
        2'h1:    wave_out <= !wave_out;
        2'h2:    wave_out <= 1'b0;
        2'h3:    wave_out <= 1'b1;
        default: wave_out <= wave_out;
      endcase
    end
  end

endmodule

// ==== src/tmr8_core.sv ====
// Top of the 8-bit timer/counter core with AHB-Lite register slave
//
// Functional notes
// - Count and compare values are 8-bit registers
// - Zero count raises bottom indication
// - 0xFF is the counter maximum
// - Top is 0xFF or compare A, flagged
// - Tick from prescaler or external pin edge
// - Clock select zero gives no tick
// - Count readable and writable at any time
// - Software count write beats clear/count
// - Tick clears, increments or decrements count
// - Wave mode split across control A and B
// - Both compares continuous, drive wave outputs
// - Compare match sets unit compare flag
// - Overflow flag set per wave mode
// - Three flags in one register, masked
// - Power-reduce bit one disables module
// - Two independent compare units, double-buffered in PWM modes only
// - Clear sets all counter bits zero
// - Flag set next tick, cleared by one
// - Count write blocks next-tick compare match
// - Mode zero wraps up, overflow at zero
`timescale 1ns/100ps
module tmr8_core (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Pins
  input  wire logic        ext_count_pin,
  output logic             wave_out_a,
  output logic             wave_out_b,
  // Interrupt requests, masked
  output logic             irq_overflow,
  output logic             irq_compare_a,
  output logic             irq_compare_b
);

  // ==========================================================================
  // Registers and internal signals
  logic [7:0]           count_value;
  logic [7:0]           timer_ctrl_a;
  logic [7:0]           timer_ctrl_b;
  logic [2:0]           timer_mask_reg;
  logic                 overflow_flag;
  logic                 power_reduce_bit;
  logic [7:0]           compare_a_value;
  logic [7:0]           compare_b_value;
  logic [7:0]           buf_a;
  logic [7:0]           buf_b;
  logic                 compare_a_flag;
  logic                 compare_b_flag;
  logic                 match_a;
  logic                 match_b;
  logic                 timer_tick;
  logic [2:0]           wave_mode_field;
  logic [2:0]           clock_select_field;
  logic                 count_down;
  logic                 pc_down;
  logic                 at_bottom;
  logic                 at_max;
  logic                 at_top;
  logic [7:0]           top_value;
  logic                 pwm_mode;
  logic                 block_match;
  logic                 clear_count;
  logic [7:0]           next_count;
  tmr8_pkg::bus_state_t bus_state;
  logic [7:0]           addr_q;
  logic                 wr_en;
  logic                 sw_count_wr;
  logic                 pc_mode;

  // ==========================================================================
  // Control field decode
  assign wave_mode_field = {timer_ctrl_b[tmr8_pkg::CTRLB_WGM2_POS],
                            timer_ctrl_a[tmr8_pkg::CTRLA_WGM1_POS],
                            timer_ctrl_a[tmr8_pkg::CTRLA_WGM0_POS]};
  assign clock_select_field = timer_ctrl_b[tmr8_pkg::CTRLB_CS_POS +: 3];
  assign pc_mode  = (wave_mode_field == tmr8_pkg::WGM_PC_MAX) ||
                    (wave_mode_field == tmr8_pkg::WGM_PC_CMPA);
  assign pwm_mode = pc_mode ||
                    (wave_mode_field == tmr8_pkg::WGM_FAST_MAX) ||
                    (wave_mode_field == tmr8_pkg::WGM_FAST_CMPA);

  // Bottom, max and top indications
  assign at_bottom = (count_value == tmr8_pkg::COUNT_BOTTOM);
  assign at_max    = (count_value == tmr8_pkg::COUNT_MAX);
  assign top_value = (wave_mode_field == tmr8_pkg::WGM_CTC ||
                      wave_mode_field == tmr8_pkg::WGM_PC_CMPA ||
                      wave_mode_field == tmr8_pkg::WGM_FAST_CMPA)
                     ? compare_a_value : tmr8_pkg::COUNT_MAX;
  assign at_top    = (count_value == top_value);

  // Direction: turn at top/bottom in phase correct, up only in normal mode
  assign count_down = pc_mode ? (at_top || (pc_down && !at_bottom)) :
                      (wave_mode_field != tmr8_pkg::WGM_NORMAL) &&
                      timer_ctrl_b[tmr8_pkg::CTRLB_DIR_POS];
  assign clear_count = timer_tick && at_top && !pc_mode &&
                       (wave_mode_field != tmr8_pkg::WGM_NORMAL);

  // ==========================================================================
  // Tick source
  tmr8_tick_gen u_tick (
    .sys_clk            (sys_clk),
    .rst_b              (rst_b),
    .enable             (!power_reduce_bit),
    .clock_select_field (clock_select_field),
    .ext_count_pin      (ext_count_pin),
    .timer_tick         (timer_tick)
  );

  // ==========================================================================
  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Address phase capture
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_state <= tmr8_pkg::BUS_IDLE;
      addr_q    <= 8'h00;
    end else if (hready) begin
      addr_q <= haddr[7:0];
      if (hsel && htrans[1]) begin
        bus_state <= hwrite ? tmr8_pkg::BUS_WRITE : tmr8_pkg::BUS_READ;
      end else begin
        bus_state <= tmr8_pkg::BUS_IDLE;
      end
    end
  end

  assign wr_en       = (bus_state == tmr8_pkg::BUS_WRITE);
  assign sw_count_wr = wr_en && (addr_q == tmr8_pkg::ADDR_COUNT);

  // Read mux, unmapped reads zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (addr_q == tmr8_pkg::ADDR_COUNT) begin
      hrdata[7:0] = count_value;
    end else if (addr_q == tmr8_pkg::ADDR_CMP_A) begin
      hrdata[7:0] = pwm_mode ? buf_a : compare_a_value;
    end else if (addr_q == tmr8_pkg::ADDR_CMP_B) begin
      hrdata[7:0] = pwm_mode ? buf_b : compare_b_value;
    end else if (addr_q == tmr8_pkg::ADDR_CTRL_A) begin
      hrdata[7:0] = timer_ctrl_a;
    end else if (addr_q == tmr8_pkg::ADDR_CTRL_B) begin
      hrdata[7:0] = timer_ctrl_b;
    end else if (addr_q == tmr8_pkg::ADDR_FLAG) begin
      hrdata[2:0] = {compare_b_flag, compare_a_flag, overflow_flag};
    end else if (addr_q == tmr8_pkg::ADDR_MASK) begin
      hrdata[2:0] = timer_mask_reg;
    end else if (addr_q == tmr8_pkg::ADDR_PWR) begin
      hrdata[0] = power_reduce_bit;
    end else if (addr_q == tmr8_pkg::ADDR_STATUS) begin
      hrdata[3:0] = {count_down, at_top, at_max, at_bottom};
    end
  end

  // ==========================================================================
  // Control registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_ctrl_a     <= tmr8_pkg::RESET_BYTE;
      timer_ctrl_b     <= tmr8_pkg::RESET_BYTE;
      timer_mask_reg   <= 3'h0;
      power_reduce_bit <= tmr8_pkg::PWR_RESET;
    end else if (wr_en) begin
      if (addr_q == tmr8_pkg::ADDR_CTRL_A) begin
        timer_ctrl_a <= hwdata[7:0];
      end else if (addr_q == tmr8_pkg::ADDR_CTRL_B) begin
        timer_ctrl_b <= {3'h0, hwdata[4:0]};
      end else if (addr_q == tmr8_pkg::ADDR_MASK) begin
        timer_mask_reg <= hwdata[2:0];
      end else if (addr_q == tmr8_pkg::ADDR_PWR) begin
        power_reduce_bit <= hwdata[tmr8_pkg::PWR_BIT_POS];
      end
    end
  end

  // ==========================================================================
  // Counter next value
  always_comb begin
    next_count = count_value;
    if (sw_count_wr) begin
      next_count = hwdata[7:0];
    end else if (clear_count) begin
      next_count = 8'h00;
    end else if (timer_tick) begin
      next_count = count_down ? count_value - 8'h01 : count_value + 8'h01;
    end
  end

  // Counter register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_value <= tmr8_pkg::RESET_BYTE;
    end else begin
      count_value <= next_count;
    end
  end

  // Phase-correct turnaround at top and bottom
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_down <= 1'b0;
    end else if (timer_tick && !sw_count_wr) begin
      if (at_top) begin
        pc_down <= 1'b1;
      end else if (at_bottom) begin
        pc_down <= 1'b0;
      end
    end
  end

  // Match blocking armed by count write until next tick
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      block_match <= 1'b0;
    end else if (sw_count_wr) begin
      block_match <= 1'b1;
    end else if (timer_tick) begin
      block_match <= 1'b0;
    end
  end

  // Overflow flag: set wins over software clear
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      overflow_flag <= 1'b0;
    end else if (timer_tick && !sw_count_wr &&
                 (pc_mode ? (at_bottom && pc_down) :
                  (wave_mode_field == tmr8_pkg::WGM_NORMAL) ?
                  (at_max && !count_down) : at_max)) begin
      overflow_flag <= 1'b1;
    end else if (wr_en && addr_q == tmr8_pkg::ADDR_FLAG &&
                 hwdata[tmr8_pkg::FLAG_OVF_POS]) begin
      overflow_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // Compare units
  tmr8_compare u_cmp_a (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .wr_value    (wr_en && addr_q == tmr8_pkg::ADDR_CMP_A),
    .wdata       (hwdata[7:0]),
    .clr_flag    (wr_en && addr_q == tmr8_pkg::ADDR_FLAG &&
                  hwdata[tmr8_pkg::FLAG_CMPA_POS]),
    .out_action  (timer_ctrl_a[tmr8_pkg::CTRLA_COMA_POS +: 2]),
    .timer_tick  (timer_tick),
    .count_value (count_value),
    .block_match (block_match || sw_count_wr),
    .buffered    (pwm_mode),
    .update_now  (timer_tick && (pc_mode ? at_top : at_bottom)),
    .cmp_value   (compare_a_value),
    .cmp_buffer  (buf_a),
    .match       (match_a),
    .cmp_flag    (compare_a_flag),
    .wave_out    (wave_out_a)
  );

  tmr8_compare u_cmp_b (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .wr_value    (wr_en && addr_q == tmr8_pkg::ADDR_CMP_B),
    .wdata       (hwdata[7:0]),
    .clr_flag    (wr_en && addr_q == tmr8_pkg::ADDR_FLAG &&
                  hwdata[tmr8_pkg::FLAG_CMPB_POS]),
    .out_action  (timer_ctrl_a[tmr8_pkg::CTRLA_COMB_POS +: 2]),
    .timer_tick  (timer_tick),
    .count_value (count_value),
    .block_match (block_match || sw_count_wr),
    .buffered    (pwm_mode),
    .update_now  (timer_tick && (pc_mode ? at_top : at_bottom)),
    .cmp_value   (compare_b_value),
    .cmp_buffer  (buf_b),
    .match       (match_b),
    .cmp_flag    (compare_b_flag),
    .wave_out    (wave_out_b)
  );

  // Masked interrupt requests
  assign irq_overflow  = overflow_flag  && timer_mask_reg[tmr8_pkg::FLAG_OVF_POS];
  assign irq_compare_a = compare_a_flag && timer_mask_reg[tmr8_pkg::FLAG_CMPA_POS];
  assign irq_compare_b = compare_b_flag && timer_mask_reg[tmr8_pkg::FLAG_CMPB_POS];

  // ==========================================================================
  // Assertions

  // Software count write lands regardless of tick
  AST_CNT_WRITE_WINS: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sw_count_wr |=> count_value == $past(hwdata[7:0]))
    else $error("count write did not take priority");

  // No tick when clock select is zero
  AST_STOP_NO_TICK: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clock_select_field == tmr8_pkg::CS_STOP |-> !timer_tick)
    else $error("tick while stopped");

  // Powered-down module holds count
  AST_PWR_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    power_reduce_bit && !sw_count_wr |=> $stable(count_value))
    else $error("count moved while powered down");

  // Normal mode increments by one per tick
  AST_NORMAL_INC: assert property (@(posedge sys_clk) disable iff (!rst_b)
    timer_tick && !sw_count_wr && wave_mode_field == tmr8_pkg::WGM_NORMAL &&
    !count_down |=> count_value == $past(count_value) + 8'h01)
    else $error("normal mode did not increment");

  // Normal mode overflow flag set when count wraps to zero
  AST_NORMAL_OVF: assert property (@(posedge sys_clk) disable iff (!rst_b)
    timer_tick && !sw_count_wr && at_max && !count_down &&
    wave_mode_field == tmr8_pkg::WGM_NORMAL |=> overflow_flag && at_bottom)
    else $error("overflow flag missing at wrap");

  // Compare A flag after a counted match
  AST_CMPA_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_b)
    timer_tick && match_a && !block_match && !sw_count_wr |=> compare_a_flag)
    else $error("compare A flag not set");

  // Compare B flag after a counted match
  AST_CMPB_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_b)
    timer_tick && match_b && !block_match && !sw_count_wr |=> compare_b_flag)
    else $error("compare B flag not set");

  // Blocked match after count write
  AST_BLOCK: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (block_match || sw_count_wr) && timer_tick
    |=> !$rose(compare_a_flag) && !$rose(compare_b_flag))
    else $error("match not blocked after count write");

  // CTC clears count at compare A
  AST_CTC_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clear_count && !sw_count_wr |=> count_value == 8'h00)
    else $error("counter not cleared at top");

  // Compare B request stays low while its mask bit is zero
  AST_IRQ_MASK: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !timer_mask_reg[tmr8_pkg::FLAG_CMPB_POS] |-> !irq_compare_b)
    else $error("unmasked compare B request");

endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the 8-bit timer core over its register bus
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module tb;
  // ==========================================================================
  // Signals
  logic        sys_clk, rst_b, hsel, hwrite, hreadyout, hresp, ext_count_pin;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        wave_out_a, wave_out_b, irq_overflow, irq_compare_a, irq_compare_b;
  logic [7:0]  mdl [0:8];
  int          failures = 0;
  int          tests_run = 0;
  int          cycles = 0;

  // Design under test, single slave so hready is its own hreadyout
  tmr8_core tmr8_core_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ext_count_pin(ext_count_pin), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
    .irq_overflow(irq_overflow), .irq_compare_a(irq_compare_a),
    .irq_compare_b(irq_compare_b));

  // Clock, 5 ns period
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic results();
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // One single word transfer, entered just after a rising edge
  task automatic xfer(input bit wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1; haddr <= {24'h0000_00, a}; htrans <= 2'b10;
    hwrite <= wr; hsize <= 3'b010;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wr ? d : 32'h0000_0000;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    r = hrdata;
  endtask

  // Write and keep the bench model in step, flags clear on one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, a, {24'h0000_00, d}, r);
    if (a == tmr8_pkg::ADDR_FLAG) mdl[a >> 2] = mdl[a >> 2] & ~d;
    else if (a < 8'h24) mdl[a >> 2] = d;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 32'h0000_0000, rv);
    `CHK(rv[7:0], e)
  endtask

  // Set mode, load count, run the timer for n+2 cycles, stop and check the count
  task automatic run(input logic [7:0] ca, input logic [7:0] cs, input logic [7:0] st,
                     input int n, input logic [7:0] e);
    wr(tmr8_pkg::ADDR_CTRL_A, ca);
    wr(tmr8_pkg::ADDR_COUNT, st);
    wr(tmr8_pkg::ADDR_CTRL_B, cs);
    repeat (n) @(posedge sys_clk);
    wr(tmr8_pkg::ADDR_CTRL_B, tmr8_pkg::CS_STOP);
    rd(tmr8_pkg::ADDR_COUNT, e);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    rst_b = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = '0; ext_count_pin = 1'b0;
    foreach (mdl[i]) mdl[i] = 8'h00;
    rv = $urandom(57519);
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    // Reset values, bottom indication and an unmapped place
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 8'h00);
    rd(8'h24, 8'h00);
    xfer(1'b0, tmr8_pkg::ADDR_STATUS, 32'h0000_0000, rv);
    `CHK(rv[0], 1'b1)
    // Random round trips with the timer stopped
    repeat (4) begin
      for (int a = 0; a < 12; a += 4) wr(8'(a), 8'($urandom));
      for (int a = 0; a < 12; a += 4) rd(8'(a), mdl[a / 4]);
    end
    repeat (20) @(posedge sys_clk);
    rd(tmr8_pkg::ADDR_COUNT, mdl[0]);
    // Maximum is also top in mode zero
    wr(tmr8_pkg::ADDR_COUNT, tmr8_pkg::COUNT_MAX);
    xfer(1'b0, tmr8_pkg::ADDR_STATUS, 32'h0000_0000, rv);
    `CHK(rv[2:0], 3'b110)
    // Run through wrap with both compares armed
    wr(tmr8_pkg::ADDR_MASK, 8'h07);
    wr(tmr8_pkg::ADDR_CTRL_A, 8'h70);
    wr(tmr8_pkg::ADDR_COUNT, 8'hF8);
    wr(tmr8_pkg::ADDR_CMP_A, 8'hFC);
    wr(tmr8_pkg::ADDR_CMP_B, 8'h02);
    wr(tmr8_pkg::ADDR_CTRL_B, tmr8_pkg::CS_DIV1);
    for (int n = 0; n < 100 && rv[2:0] !== 3'h7; n++)
      xfer(1'b0, tmr8_pkg::ADDR_FLAG, 32'h0000_0000, rv);
    wr(tmr8_pkg::ADDR_CTRL_B, tmr8_pkg::CS_STOP);
    `CHK(rv[2:0], 3'h7)
    `CHK({irq_overflow, irq_compare_a, irq_compare_b}, 3'b111)
    // A toggled once from low, B set
    `CHK({wave_out_a, wave_out_b}, 2'b11)
    mdl[5] = 8'h07;
    // Masking and write-one clearing
    wr(tmr8_pkg::ADDR_MASK, 8'h05);
    wr(tmr8_pkg::ADDR_FLAG, 8'h03);
    rd(tmr8_pkg::ADDR_FLAG, mdl[5]);
    `CHK({irq_overflow, irq_compare_a, irq_compare_b}, 3'b001)
    wr(tmr8_pkg::ADDR_FLAG, 8'h07);
    // Count write masks the match on the next tick
    wr(tmr8_pkg::ADDR_CMP_A, 8'h40);
    wr(tmr8_pkg::ADDR_COUNT, 8'h40);
    wr(tmr8_pkg::ADDR_CTRL_B, tmr8_pkg::CS_DIV1);
    wr(tmr8_pkg::ADDR_CTRL_B, tmr8_pkg::CS_STOP);
    rd(tmr8_pkg::ADDR_FLAG, 8'h00);
    `CHK(wave_out_a, 1'b1)
    // Power-reduced module does not count
    wr(tmr8_pkg::ADDR_COUNT, 8'h10);
    wr(tmr8_pkg::ADDR_PWR, 8'h01);
    wr(tmr8_pkg::ADDR_CTRL_B, tmr8_pkg::CS_DIV1);
    repeat (10) @(posedge sys_clk);
    rd(tmr8_pkg::ADDR_COUNT, 8'h10);
    wr(tmr8_pkg::ADDR_CTRL_B, tmr8_pkg::CS_STOP);
    wr(tmr8_pkg::ADDR_PWR, 8'h00);
    // External pin, falling then rising edge, five pulses each
    for (int c = 6; c < 8; c++) begin
      wr(tmr8_pkg::ADDR_COUNT, 8'h20);
      wr(tmr8_pkg::ADDR_CTRL_B, 8'(c));
      repeat (5) begin
        ext_count_pin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        ext_count_pin <= 1'b0;
        repeat (4) @(posedge sys_clk);
      end
      repeat (8) @(posedge sys_clk);
      wr(tmr8_pkg::ADDR_CTRL_B, tmr8_pkg::CS_STOP);
      rd(tmr8_pkg::ADDR_COUNT, 8'h25);
    end
    // Divide by 8 over an 82-cycle run window gives ten ticks
    run(8'h00, tmr8_pkg::CS_DIV8, 8'h80, 80, 8'h8A);
    // Clear at top five: 13 ticks from zero end at one
    wr(tmr8_pkg::ADDR_CMP_A, 8'h05);
    run(8'h02, tmr8_pkg::CS_DIV1, 8'h00, 11, 8'h01);
    // Phase correct: two ticks up to maximum, then three back down
    run(8'h01, tmr8_pkg::CS_DIV1, 8'hFD, 3, 8'hFC);
    results();
  end
endmodule
